// ---- bench/ddr2_ctrl_model.sv ----
// Controller-side model: free-running memory clock and the command pins.
// Assumes the bench calls its tasks only after reset has been released.
`timescale 1ns/10ps
module ddr2_ctrl_model (
  input  wire logic   mclk,
  output logic        memClk,
  output logic        cke,
  output logic        csN,
  output logic        rasN,
  output logic        casN,
  output logic        weN,
  output logic [1:0]  bankAddr,
  output logic [13:0] addr
);
  logic               odt;
  ////////////////////////////////////////////////////////////////////////////////
  // Memory clock runs free; odd start offset keeps it unrelated to mclk
  initial begin
    memClk = 1'b0;
    #3.3;
    forever #80 memClk = ~memClk;
  end

  // Pins at time zero; CKE low while power comes up
  initial begin
    cke = 1'b0;
    odt = 1'b0; // Termination kept off throughout
    {csN, rasN, casN, weN} = 4'hF;
    bankAddr = 2'h0;
    addr = 14'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One command per memory clock; pins move in the low phase, far from the rise
  task automatic issue(input logic desel, input logic [2:0] cmd, input logic [1:0] ba, input logic [13:0] a);
    @(negedge memClk);
    @(posedge mclk);
    #1;
    {csN, rasN, casN, weN} = {desel, cmd};
    bankAddr = ba;
    addr = a;
    @(posedge memClk);
    @(negedge memClk);
    @(posedge mclk);
    #1;
    // Deselect; lines show the inverse so a stale value cannot pass
    {csN, rasN, casN, weN} = 4'hF;
    bankAddr = ~bankAddr;
    addr = ~addr;
  endtask

  // Power-up wait, CKE rise, then the fixed initialisation order
  task automatic power_up(input logic [13:0] mrOp, input logic [13:0] emrOp);
    repeat (1250) @(posedge memClk); // 200 us of 160 ns clocks
    @(posedge mclk);
    #1;
    cke = 1'b1;
    repeat (3) @(posedge memClk); // 480 ns of deselect
    issue(1'b0, ddr2_cmd_pkg::CMD_PRE, 2'h0, 14'h0400);
    issue(1'b0, ddr2_cmd_pkg::CMD_MRS, ddr2_cmd_pkg::SEL_EMR2, 14'h0000);
    issue(1'b0, ddr2_cmd_pkg::CMD_MRS, ddr2_cmd_pkg::SEL_EMR3, 14'h0000);
    issue(1'b0, ddr2_cmd_pkg::CMD_MRS, ddr2_cmd_pkg::SEL_EMR1, emrOp & 14'h1C7E);
    issue(1'b0, ddr2_cmd_pkg::CMD_MRS, ddr2_cmd_pkg::SEL_MR, (mrOp | 14'h0100) & 14'h1F7F);
    issue(1'b0, ddr2_cmd_pkg::CMD_PRE, 2'h0, 14'h0400);
    repeat (2) issue(1'b0, ddr2_cmd_pkg::CMD_REF, 2'h0, 14'h0000);
    issue(1'b0, ddr2_cmd_pkg::CMD_MRS, ddr2_cmd_pkg::SEL_MR, mrOp & 14'h1E7F);
    repeat (200) @(posedge memClk);
    issue(1'b0, ddr2_cmd_pkg::CMD_MRS, ddr2_cmd_pkg::SEL_EMR1, (emrOp & 14'h1C7E) | 14'h0380);
    issue(1'b0, ddr2_cmd_pkg::CMD_MRS, ddr2_cmd_pkg::SEL_EMR1, emrOp & 14'h1C7E);
  endtask
endmodule // ddr2_ctrl_model

// ---- bench/ddr2_init_and_mode_register_tb_top.sv ----
// Self-checking bench for the command decoder, driven by the controller model.
// Assumes a 100 MHz mclk and the 160 ns memory clock made by the model.
`timescale 1ns/10ps
module ddr2_init_and_mode_register_tb_top;
  logic        mclk;
  logic        nrst;
  logic        memClk;
  logic        cke;
  logic        csN;
  logic        rasN;
  logic        casN;
  logic        weN;
  logic [1:0]  bankAddr;
  logic [13:0] addr;
  logic [13:0] modeReg;
  logic [2:0]  casLatency;
  logic [2:0]  writeRecovery;
  logic        dllResetPulse;
  logic        dllLocked;
  logic [3:0]  bankOpen;
  logic [13:0] openRow;
  logic [1:0]  accBank;
  logic        accWrite;
  logic        autoPrecharge;
  logic        burstActive;
  logic [9:0]  burstCol;
  logic        protoError;
  int          err_total = 0;
  int          total_checks = 0;
  int          cycles = 0;
  int          pulses = 0;
  logic [13:0] mrExp;
  logic [13:0] a;
  logic [13:0] row;
  logic [1:0]  ba;
  logic        wr;
  logic        len8;

  ////////////////////////////////////////////////////////////////////////////////
  ddr2_cmd_decoder uut (
    .mclk(mclk), .nrst(nrst), .memClk(memClk), .cke(cke), .csN(csN), .rasN(rasN), .casN(casN),
    .weN(weN), .bankAddr(bankAddr), .addr(addr), .modeReg(modeReg), .casLatency(casLatency),
    .writeRecovery(writeRecovery), .dllResetPulse(dllResetPulse), .dllLocked(dllLocked),
    .bankOpen(bankOpen), .openRow(openRow), .accBank(accBank), .accWrite(accWrite),
    .autoPrecharge(autoPrecharge), .burstActive(burstActive), .burstCol(burstCol), .protoError(protoError)
  );
  ddr2_ctrl_model ctl (
    .mclk(mclk), .memClk(memClk), .cke(cke), .csN(csN), .rasN(rasN), .casN(casN),
    .weN(weN), .bankAddr(bankAddr), .addr(addr)
  );

  // System clock
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  // Hang guard and count of DLL reset pulses; mid-cycle sampling avoids edge races
  always @(negedge mclk) begin
    cycles++;
    if (dllResetPulse === 1'b1) pulses++;
    if (cycles == 60000) begin
      err_total++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Legal operating op-code: test bit and DLL reset kept low
  function automatic logic [13:0] rand_mr();
    logic [13:0] m;
    m = 14'($urandom);
    m[2:0] = $urandom_range(1) ? ddr2_cmd_pkg::BL_CODE8 : ddr2_cmd_pkg::BL_CODE4;
    m[8:7] = 2'h0;
    return m;
  endfunction

  // Column of beat i, wrapping inside the 4 or 8 block
  function automatic logic [9:0] beat_col(logic [9:0] s, logic l8, logic il, int i);
    logic [9:0] mask;
    logic [9:0] idx;
    mask = l8 ? 10'h007 : 10'h003;
    idx = il ? ((s & mask) ^ 10'(i)) : ((s & mask) + 10'(i));
    return (s & ~mask) | (idx & mask);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    nrst = 1'b0;
    repeat (16) @(posedge mclk);
    #1;
    nrst = 1'b1;
    void'($urandom(61035));
    check(modeReg, ddr2_cmd_pkg::MR_RESET);
    mrExp = rand_mr();
    ctl.power_up(mrExp, 14'($urandom));
    check(pulses, 1);
    check(modeReg, mrExp & 14'h1E7F);
    check(dllLocked, 1'b1);
    ctl.issue(1'b1, ddr2_cmd_pkg::CMD_MRS, ddr2_cmd_pkg::SEL_MR, ~mrExp);
    check(modeReg, mrExp & 14'h1E7F);
    // Program, open a row, burst, close: random with corner columns first
    for (int n = 0; n < 24; n++) begin
      mrExp = rand_mr();
      ctl.issue(1'b0, ddr2_cmd_pkg::CMD_MRS, ddr2_cmd_pkg::SEL_MR, mrExp);
      check(modeReg, mrExp);
      check(casLatency, mrExp[6:4]);
      check(writeRecovery, mrExp[11:9]);
      ba = 2'($urandom);
      row = 14'($urandom);
      ctl.issue(1'b0, ddr2_cmd_pkg::CMD_ACT, ba, row);
      check(bankOpen[ba], 1'b1);
      check(openRow, row);
      a = (n == 0) ? 14'h03FF : (n == 1) ? 14'h0000 : 14'($urandom);
      wr = 1'($urandom);
      ctl.issue(1'b0, wr ? ddr2_cmd_pkg::CMD_WR : ddr2_cmd_pkg::CMD_RD, ba, a);
      check(accBank, ba);
      check(accWrite, wr);
      check(autoPrecharge, a[10]);
      len8 = (mrExp[2:0] == ddr2_cmd_pkg::BL_CODE8);
      for (int i = 0; i < (len8 ? 8 : 4); i++) begin
        check(burstActive, 1'b1);
        check(burstCol, beat_col(a[9:0], len8, mrExp[3], i));
        @(posedge memClk);
        repeat (8) @(posedge mclk);
      end
      @(posedge memClk);
      repeat (8) @(posedge mclk);
      check(burstActive, 1'b0);
      // Odd passes close the one bank alone, even passes close all
      ctl.issue(1'b0, ddr2_cmd_pkg::CMD_PRE, ba, n[0] ? 14'h0000 : 14'h0400);
      check(bankOpen, 4'h0);
    end
    check(protoError, 1'b0);
    // DLL reset mid-run, then a read before lock is flagged
    ctl.issue(1'b0, ddr2_cmd_pkg::CMD_MRS, ddr2_cmd_pkg::SEL_MR, mrExp | 14'h0100);
    check(pulses, 2);
    check(dllLocked, 1'b0);
    ctl.issue(1'b0, ddr2_cmd_pkg::CMD_ACT, 2'h1, 14'h0000);
    ctl.issue(1'b0, ddr2_cmd_pkg::CMD_RD, 2'h1, 14'h0000);
    check(protoError, 1'b1);
    repeat (200) @(posedge memClk);
    check(dllLocked, 1'b1);
    check(ctl.odt, 1'b0);
    results();
  end
endmodule // ddr2_init_and_mode_register_tb_top

// ---- include/burst_if.sv ----
// Carrier between the decoder and the burst column unit.
// Assumes both ends run on mclk.
`timescale 1ns/10ps
interface burst_if;
  logic                               start;
  logic [ddr2_cmd_pkg::COL_BITS-1:0]  startCol;
  logic                               len8;
  logic                               interleave;
  logic                               step;
  logic [ddr2_cmd_pkg::COL_BITS-1:0]  col;
  logic                               busy;
  logic                               last;
  modport ctrl (output start, output startCol, output len8, output interleave, output step,
                input col, input busy, input last);
  modport unit (input start, input startCol, input len8, input interleave, input step,
                output col, output busy, output last);
endinterface

// ---- include/ddr2_cmd_pkg.sv ----
// Constants and types shared by the command decoder and its column unit.
// Assumes one 100 MHz clock domain; the memory clock arrives as a pin and is sampled.
package ddr2_cmd_pkg;
  localparam int ROW_BITS       = 14;
  localparam int COL_BITS       = 10;
  localparam int BANKS          = 4;
  // Mode register field positions; AP_POS is the auto-precharge address bit
  localparam int MR_BL_LSB      = 0;
  localparam int MR_BT_POS      = 3;
  localparam int MR_CL_LSB      = 4;
  localparam int MR_TM_POS      = 7;
  localparam int MR_DLLRST_POS  = 8;
  localparam int MR_WR_LSB      = 9;
  localparam int AP_POS         = 10;
  // Burst length codes
  localparam logic [2:0] BL_CODE4 = 3'h2;
  localparam logic [2:0] BL_CODE8 = 3'h3;
  // Register selects on the bank pins
  localparam logic [1:0] SEL_MR   = 2'h0;
  localparam logic [1:0] SEL_EMR1 = 2'h1;
  localparam logic [1:0] SEL_EMR2 = 2'h2;
  localparam logic [1:0] SEL_EMR3 = 2'h3;
  // Command codes {ras_n, cas_n, we_n} with chip select low
  localparam logic [2:0] CMD_MRS  = 3'h0;
  localparam logic [2:0] CMD_REF  = 3'h1;
  localparam logic [2:0] CMD_PRE  = 3'h2;
  localparam logic [2:0] CMD_ACT  = 3'h3;
  localparam logic [2:0] CMD_WR   = 3'h4;
  localparam logic [2:0] CMD_RD   = 3'h5;
  // Reset values
  localparam logic [13:0] MR_RESET = 14'h0000;
  // DLL lock wait after reset, in memory clocks
  localparam int DLL_LOCK_CLKS  = 200;

  typedef enum logic [2:0] {
    BST_IDLE = 3'h1,
    BST_RUN  = 3'h2,
    BST_DONE = 3'h4
  } burst_state_t;
endpackage

// ---- src/burst_column_unit.sv ----
// Burst column sequencer: walks 4 or 8 columns in sequential or interleaved order.
// Assumes the controller pulses start once per access and step once per beat.
`timescale 1ns/10ps
module burst_column_unit (
  input  wire logic mclk,
  input  wire logic nrst,
  burst_if.unit     bus
);
  typedef struct packed {
    ddr2_cmd_pkg::burst_state_t     st;
    logic [ddr2_cmd_pkg::COL_BITS-1:0] base;
    logic [2:0]                     cnt;
    logic                           len8;
    logic                           il;
  } unit_state_t;
  unit_state_t s_q, s_d;
  logic [2:0] offs;

  ////////////////////////////////////////////////////////////////////////////
  // Offset within the burst block; interleave xors, sequential adds
  always_comb begin
    if (s_q.il) begin
      offs = s_q.base[2:0] ^ s_q.cnt;
    end else begin
      offs = 3'(s_q.base[2:0] + s_q.cnt);
    end
    if (!s_q.len8) begin
      offs[2] = s_q.base[2]; // Wrap inside a four-column block
    end
  end

  // Next state of the sequencer
  always_comb begin
    s_d = s_q;
    case (s_q.st)
      ddr2_cmd_pkg::BST_IDLE: begin
        if (bus.start) begin
          s_d.st   = ddr2_cmd_pkg::BST_RUN;
          s_d.base = bus.startCol;
          s_d.cnt  = 3'h0;
          s_d.len8 = bus.len8;
          s_d.il   = bus.interleave;
        end
      end
      ddr2_cmd_pkg::BST_RUN: begin
        if (bus.step) begin
          if (s_q.cnt == (s_q.len8 ? 3'h7 : 3'h3)) begin
            s_d.st = ddr2_cmd_pkg::BST_DONE;
          end else begin
            s_d.cnt = 3'(s_q.cnt + 3'h1);
          end
        end
      end
      default: s_d.st = ddr2_cmd_pkg::BST_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s_q <= '{st: ddr2_cmd_pkg::BST_IDLE, base: '0, cnt: 3'h0, len8: 1'b0, il: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.col  = {s_q.base[ddr2_cmd_pkg::COL_BITS-1:3], offs};
  assign bus.busy = (s_q.st == ddr2_cmd_pkg::BST_RUN);
  assign bus.last = (s_q.st == ddr2_cmd_pkg::BST_DONE);

  // Sequential bursts: low column bits must step by one per beat
  property p_seq_col;
    @(posedge mclk) disable iff (!nrst)
      (bus.busy && !s_q.il && bus.step && s_q.cnt != 3'h3 && s_q.cnt != 3'h7) |=>
        bus.col[1:0] == 2'($past(bus.col[1:0]) + 2'h1);
  endproperty
  a_seq_col: assert property (p_seq_col) else $error("sequential column step wrong");
endmodule // burst_column_unit

// ---- src/ddr2_cmd_decoder.sv ----
// DDR2 device-side command decoder: mode register, row open, burst column sequencing.
// Assumes command pins come from a controller clocked by memClk, sampled here on mclk.
`timescale 1ns/10ps
module ddr2_cmd_decoder #(
  parameter int ROW_W = ddr2_cmd_pkg::ROW_BITS
) (
  input  wire logic                             mclk,
  input  wire logic                             nrst,
  input  wire logic                             memClk,
  input  wire logic                             cke,
  input  wire logic                             csN,
  input  wire logic                             rasN,
  input  wire logic                             casN,
  input  wire logic                             weN,
  input  wire logic [1:0]                       bankAddr,
  input  wire logic [13:0]                      addr,
  output logic [13:0]                           modeReg,
  output logic [2:0]                            casLatency,
  output logic [2:0]                            writeRecovery,
  output logic                                  dllResetPulse,
  output logic                                  dllLocked,
  output logic [3:0]                            bankOpen,
  output logic [ROW_W-1:0]                      openRow,
  output logic [1:0]                            accBank,
  output logic                                  accWrite,
  output logic                                  autoPrecharge,
  output logic                                  burstActive,
  output logic [ddr2_cmd_pkg::COL_BITS-1:0]     burstCol,
  output logic                                  protoError
);
  // Row width limited to the two organisations
  if (ROW_W != 13 && ROW_W != 14) begin : g_row_check
    $error("ROW_W must be 13 or 14");
  end

  typedef struct packed {
    logic [1:0]  clkSync;
    logic        clkPrev;
    logic [1:0]  ckeS;
    logic [1:0]  csS;
    logic [1:0]  rasS;
    logic [1:0]  casS;
    logic [1:0]  weS;
    logic [3:0]  baS;
    logic [27:0] aS;
    logic [13:0] mr;
    logic [13:0] emr1;
    logic [13:0] emr2;
    logic [13:0] emr3;
    logic        dllPulse;
    logic [7:0]  lockCnt;
    logic        locked;
    logic [3:0]  open;
    logic [ROW_W-1:0] row;
    logic [1:0]  bank;
    logic        wr;
    logic        ap;
    logic        err;
    logic [ddr2_cmd_pkg::COL_BITS-1:0] col;
    logic        act;
  } dec_state_t;
  dec_state_t s_q, s_d;

  burst_if bif ();
  burst_column_unit u_burst (.mclk(mclk), .nrst(nrst), .bus(bif));

  logic        risePulse;
  logic [2:0]  cmd;
  logic        cmdValid;
  logic [1:0]  ba;
  logic [13:0] a;

  ////////////////////////////////////////////////////////////////////////////
  // Sampled pins: second stage only feeds logic
  assign risePulse = s_q.clkSync[1] & ~s_q.clkPrev;
  assign ba        = s_q.baS[3:2];
  assign a         = s_q.aS[27:14];
  assign cmd       = {s_q.rasS[1], s_q.casS[1], s_q.weS[1]};
  // Deselect masks all commands; CKE low means no command either
  assign cmdValid  = risePulse & ~s_q.csS[1] & s_q.ckeS[1];

  // Burst unit control: one beat per rising memory clock edge
  assign bif.start      = cmdValid && (cmd == ddr2_cmd_pkg::CMD_RD || cmd == ddr2_cmd_pkg::CMD_WR);
  assign bif.startCol   = a[ddr2_cmd_pkg::COL_BITS-1:0];
  assign bif.len8       = (s_q.mr[2:0] == ddr2_cmd_pkg::BL_CODE8);
  assign bif.interleave = s_q.mr[ddr2_cmd_pkg::MR_BT_POS];
  assign bif.step       = risePulse;

  ////////////////////////////////////////////////////////////////////////////
  // Command decode and state update
  always_comb begin
    s_d          = s_q;
    s_d.clkSync  = {s_q.clkSync[0], memClk};
    s_d.clkPrev  = s_q.clkSync[1];
    s_d.ckeS     = {s_q.ckeS[0], cke};
    s_d.csS      = {s_q.csS[0], csN};
    s_d.rasS     = {s_q.rasS[0], rasN};
    s_d.casS     = {s_q.casS[0], casN};
    s_d.weS      = {s_q.weS[0], weN};
    s_d.baS      = {s_q.baS[1:0], bankAddr};
    s_d.aS       = {s_q.aS[13:0], addr};
    s_d.dllPulse = 1'b0;
    s_d.col      = bif.col; // Registered copy keeps the output on a flop
    s_d.act      = bif.busy;
    // DLL lock counting in memory clocks
    if (risePulse && !s_q.locked) begin
      if (s_q.lockCnt == 8'(ddr2_cmd_pkg::DLL_LOCK_CLKS - 1)) begin
        s_d.locked = 1'b1;
      end else begin
        s_d.lockCnt = 8'(s_q.lockCnt + 8'h01);
      end
    end
    if (cmdValid) begin
      case (cmd)
        ddr2_cmd_pkg::CMD_MRS: begin
          // Array untouched: register copies, DLL lock state and error flag change
          if (s_q.open != 4'h0) begin
            s_d.err = 1'b1;
          end
          if (ba == ddr2_cmd_pkg::SEL_MR) begin
            s_d.mr = a;
            if (a[ddr2_cmd_pkg::MR_DLLRST_POS]) begin
              s_d.dllPulse = 1'b1;
              s_d.locked   = 1'b0;
              s_d.lockCnt  = 8'h00;
            end
            if (a[ddr2_cmd_pkg::MR_TM_POS]) begin
              s_d.err = 1'b1;
            end
          end else if (ba == ddr2_cmd_pkg::SEL_EMR1) begin
            s_d.emr1 = a;
          end else if (ba == ddr2_cmd_pkg::SEL_EMR2) begin
            s_d.emr2 = a;
          end else begin
            s_d.emr3 = a;
          end
        end
        ddr2_cmd_pkg::CMD_ACT: begin
          s_d.open[ba] = 1'b1;
          s_d.row      = a[ROW_W-1:0];
          s_d.bank     = ba;
        end
        ddr2_cmd_pkg::CMD_PRE: begin
          if (a[ddr2_cmd_pkg::AP_POS]) begin
            s_d.open = 4'h0;
          end else begin
            s_d.open[ba] = 1'b0;
          end
        end
        ddr2_cmd_pkg::CMD_RD, ddr2_cmd_pkg::CMD_WR: begin
          if (!s_q.open[ba]) begin
            s_d.err = 1'b1;
          end
          if (cmd == ddr2_cmd_pkg::CMD_RD && !s_q.locked) begin
            s_d.err = 1'b1;
          end
          s_d.bank = ba;
          s_d.wr   = (cmd == ddr2_cmd_pkg::CMD_WR);
          s_d.ap   = a[ddr2_cmd_pkg::AP_POS];
          if (a[ddr2_cmd_pkg::AP_POS]) begin
            s_d.open[ba] = 1'b0;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.mr <= ddr2_cmd_pkg::MR_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign burstCol      = s_q.col;
  assign burstActive   = s_q.act;
  assign modeReg       = s_q.mr;
  assign casLatency    = s_q.mr[6:4];
  assign writeRecovery = s_q.mr[11:9];
  assign dllResetPulse = s_q.dllPulse;
  assign dllLocked     = s_q.locked;
  assign bankOpen      = s_q.open;
  assign openRow       = s_q.row;
  assign accBank       = s_q.bank;
  assign accWrite      = s_q.wr;
  assign autoPrecharge = s_q.ap;
  assign protoError    = s_q.err;

  ////////////////////////////////////////////////////////////////////////////
  property p_mrs_load;
    @(posedge mclk) disable iff (!nrst)
      (cmdValid && cmd == ddr2_cmd_pkg::CMD_MRS && ba == ddr2_cmd_pkg::SEL_MR) |=> modeReg == $past(a);
  endproperty
  a_mrs_load: assert property (p_mrs_load) else $error("mode register not loaded");
  property p_act_row;
    @(posedge mclk) disable iff (!nrst)
      (cmdValid && cmd == ddr2_cmd_pkg::CMD_ACT) |=> bankOpen[accBank] && openRow == $past(a[ROW_W-1:0]);
  endproperty
  a_act_row: assert property (p_act_row) else $error("activate row not captured");
  property p_ap;
    @(posedge mclk) disable iff (!nrst)
      (cmdValid && cmd == ddr2_cmd_pkg::CMD_RD) |=> autoPrecharge == $past(a[10]) && !accWrite;
  endproperty
  a_ap: assert property (p_ap) else $error("auto-precharge flag wrong");
  property p_dll;
    @(posedge mclk) disable iff (!nrst)
      dllResetPulse |-> !dllLocked ##1 !dllLocked;
  endproperty
  a_dll: assert property (p_dll) else $error("lock not cleared by dll reset");
  property p_burst_start;
    @(posedge mclk) disable iff (!nrst)
      bif.start && !bif.busy |=> ##1 burstActive;
  endproperty
  a_burst_start: assert property (p_burst_start) else $error("burst did not start");
  property p_fields;
    @(posedge mclk) disable iff (!nrst)
      (cmdValid && cmd == ddr2_cmd_pkg::CMD_MRS && ba == ddr2_cmd_pkg::SEL_MR) |=>
        casLatency == $past(a[6:4]) && writeRecovery == $past(a[11:9]);
  endproperty
  a_fields: assert property (p_fields) else $error("mode fields mis-decoded");
  property p_mrs_busy;
    @(posedge mclk) disable iff (!nrst)
      (cmdValid && cmd == ddr2_cmd_pkg::CMD_MRS && bankOpen != 4'h0) |=> protoError;
  endproperty
  a_mrs_busy: assert property (p_mrs_busy) else $error("mode write with open bank missed");
  property p_rd_closed;
    @(posedge mclk) disable iff (!nrst)
      (cmdValid && cmd == ddr2_cmd_pkg::CMD_RD && !bankOpen[ba]) |=> protoError;
  endproperty
  a_rd_closed: assert property (p_rd_closed) else $error("read to closed bank missed");
endmodule // ddr2_cmd_decoder
